// ==== hw/hsm_token_host.sv ====
// Overview of operation
// - write zero requests, same side writes one releases
// - drop select or enable between poll reads
// - write zero first, then read to test
// - after failure keep polling or write one
// - write one to drop an unneeded token
// - write one to all eight tokens first
// - keep ram enable high during token access
`default_nettype none

module hsm_token_host
    import hsm_pkg::*;
#(
    parameter logic [3:0] POLL_TRIES = POLL_TRIES_RST  // extra reads after a failed request
)
(
    input  wire logic              clock,             // 25 MHz system clock
    input  wire logic              rst,               // synchronous reset, high
    input  wire logic              cmd_valid,         // command request
    input  wire logic [1:0]        cmd_op,            // test, acquire or release
    input  wire logic [IDX_W-1:0]  cmd_index,         // token number
    output logic                   cmd_ready,         // idle, command accepted
    output logic                   rsp_done,          // one-cycle completion pulse
    output logic                   rsp_granted,       // this port holds the token
    output logic                   rsp_flag,          // last flag value read
    output logic                   token_select_n,    // token space select pin
    output logic                   ce_n,              // ram chip enable pin
    output logic                   oe_n,              // output enable pin
    output logic                   rw_n,              // write strobe pin, low writes
    output logic [IDX_W-1:0]       token_index,       // low address pins
    input  wire logic [DATA_W-1:0] port_data_bus_in,  // data pins, level seen
    output logic [DATA_W-1:0]      port_data_bus_out, // data pins, driven value
    output logic                   port_data_bus_oe   // high while driving data
);

    typedef enum logic [2:0] {
        ST_INIT, ST_IDLE, ST_WSET, ST_WSTB, ST_WREC, ST_RON, ST_RGAP, ST_DONE
    } hsm_state_t;

    hsm_state_t       state_reg,   state_next;
    logic [3:0]       cnt_reg,     cnt_next;
    logic [3:0]       tries_reg,   tries_next;
    logic [IDX_W-1:0] idx_reg,     idx_next;
    hsm_op_t          op_reg,      op_next;
    logic             wval_reg,    wval_next;
    logic             flag_reg,    flag_next;
    logic             init_reg,    init_next;
    logic             granted_reg, granted_next;
    logic             done_next;

    hsm_sync_if sif ();

    assign sif.raw = port_data_bus_in;

    hsm_pin_sync u_sync (
        .clock (clock),
        .rst   (rst),
        .sif   (sif)
    );

    // decode of the pin levels wanted in the coming cycle
    wire logic cnt_last   = (cnt_reg == CNT_ONE);
    wire logic wr_next    = (state_next == ST_WSET) || (state_next == ST_WSTB)
                            || (state_next == ST_WREC);
    wire logic rd_next    = (state_next == ST_RON);
    wire logic strobe_nxt = (state_next == ST_WSTB);
    wire logic read_bit   = sif.stable[0];  // all bits carry the flag; bit zero suffices

    // sequencing of init, write and read cycles
    always_comb
    begin
        state_next   = state_reg;
        cnt_next     = cnt_reg - CNT_ONE;
        tries_next   = tries_reg;
        idx_next     = idx_reg;
        op_next      = op_reg;
        wval_next    = wval_reg;
        flag_next    = flag_reg;
        init_next    = init_reg;
        granted_next = granted_reg;
        done_next    = 1'b0;
        case (state_reg)
            ST_INIT:
            begin
                state_next = ST_WSET;  // free every token before taking commands
            end
            ST_WSET:
            begin
                state_next = ST_WSTB;
                cnt_next   = WR_CYC;
            end
            ST_WSTB:
            begin
                if (cnt_last)
                begin
                    state_next = ST_WREC;
                end
            end
            ST_WREC:
            begin
                if (init_reg)
                begin
                    if (idx_reg == TOK_LAST)
                    begin
                        init_next  = 1'b0;
                        state_next = ST_IDLE;
                    end
                    else
                    begin
                        idx_next   = idx_reg + 3'h1;  // walk all eight tokens
                        state_next = ST_WSET;
                    end
                end
                else if (op_reg == HSM_OP_ACQUIRE && !wval_reg)
                begin
                    state_next = ST_RON;  // test only after the request write
                    cnt_next   = RD_CYC;
                end
                else
                begin
                    granted_next = 1'b0;  // release or withdrawal leaves nothing held
                    state_next   = ST_DONE;
                end
            end
            ST_IDLE:
            begin
                if (cmd_valid)
                begin
                    op_next    = hsm_op_t'(cmd_op);
                    idx_next   = cmd_index;
                    tries_next = POLL_TRIES;
                    wval_next  = (cmd_op == HSM_OP_RELEASE);  // zero requests, one frees
                    if (cmd_op == HSM_OP_TEST)
                    begin
                        state_next = ST_RON;
                        cnt_next   = RD_CYC;
                    end
                    else
                    begin
                        state_next = ST_WSET;
                    end
                end
            end
            ST_RON:
            begin
                if (cnt_last)
                begin
                    flag_next  = read_bit;
                    state_next = ST_RGAP;  // drop select and enable so the next read refreshes
                    cnt_next   = GAP_CYC;
                end
            end
            ST_RGAP:
            begin
                if (cnt_last)
                begin
                    if (op_reg != HSM_OP_ACQUIRE || !flag_reg)
                    begin
                        granted_next = !flag_reg;
                        state_next   = ST_DONE;
                    end
                    else if (tries_reg != 4'h0)
                    begin
                        tries_next = tries_reg - 4'h1;  // keep polling the failed token
                        state_next = ST_RON;
                        cnt_next   = RD_CYC;
                    end
                    else
                    begin
                        wval_next  = 1'b1;  // give up: withdraw the pending request
                        state_next = ST_WSET;
                    end
                end
            end
            ST_DONE:
            begin
                done_next  = 1'b1;
                state_next = ST_IDLE;
            end
            default:
            begin
                state_next = ST_IDLE;
            end
        endcase
    end

    // state registers
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            state_reg   <= ST_INIT;
            cnt_reg     <= 4'h0;
            tries_reg   <= 4'h0;
            idx_reg     <= TOK_FIRST;
            op_reg      <= HSM_OP_TEST;
            wval_reg    <= 1'b1;
            flag_reg    <= 1'b1;
            init_reg    <= 1'b1;
            granted_reg <= 1'b0;
        end
        else
        begin
            state_reg   <= state_next;
            cnt_reg     <= cnt_next;
            tries_reg   <= tries_next;
            idx_reg     <= idx_next;
            op_reg      <= op_next;
            wval_reg    <= wval_next;
            flag_reg    <= flag_next;
            init_reg    <= init_next;
            granted_reg <= granted_next;
        end
    end

    // pin and user outputs, each straight from a flop
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            token_select_n    <= 1'b1;
            ce_n              <= 1'b1;
            oe_n              <= 1'b1;
            rw_n              <= 1'b1;
            token_index       <= TOK_FIRST;
            port_data_bus_out <= BUS_RST;
            port_data_bus_oe  <= 1'b0;
            cmd_ready         <= 1'b0;
            rsp_done          <= 1'b0;
        end
        else
        begin
            token_select_n    <= !(wr_next || rd_next);
            ce_n              <= 1'b1;  // ram side never enabled here
            oe_n              <= !rd_next;
            rw_n              <= !strobe_nxt;
            token_index       <= idx_next;
            port_data_bus_out <= {DATA_W{wval_next}};  // only bit zero counts on the far side
            port_data_bus_oe  <= wr_next;  // data held one cycle past the strobe edge
            cmd_ready         <= (state_next == ST_IDLE);
            rsp_done          <= done_next;
        end
    end

    assign rsp_granted = granted_reg;
    assign rsp_flag    = flag_reg;

    // ---- checks ----
    localparam int CHK_CMD_MAX = 8;
    localparam int CHK_WR_RD   = 4;

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);

    sequence s_strobe_one;
        !rw_n && !token_select_n && port_data_bus_oe && port_data_bus_out[0];
    endsequence

    sequence s_strobe_zero;
        !rw_n && !token_select_n && port_data_bus_oe && !port_data_bus_out[0];
    endsequence

    sequence s_read_on;
        !oe_n && !token_select_n && !port_data_bus_oe;
    endsequence

    chk_ce_held_off: assert property (!token_select_n |-> ce_n)
        else $error("ram enable active during token access");

    chk_acquire_zero: assert property (
        (cmd_ready && cmd_valid && cmd_op == HSM_OP_ACQUIRE) |-> ##[1:CHK_CMD_MAX] s_strobe_zero)
        else $error("acquire did not write zero");

    chk_release_one: assert property (
        (cmd_ready && cmd_valid && cmd_op == HSM_OP_RELEASE) |-> ##[1:CHK_CMD_MAX] s_strobe_one)
        else $error("release did not write one");

    chk_write_then_read: assert property (
        (!init_reg && $rose(rw_n) && !port_data_bus_out[0]) |-> ##[1:CHK_WR_RD] s_read_on)
        else $error("request write not followed by test read");

    chk_read_window: assert property ($fell(oe_n) |-> (!oe_n) [*6] ##1 (oe_n && token_select_n))
        else $error("read window length or release wrong");

    chk_fail_withdraw: assert property (
        (state_reg == ST_RGAP && cnt_last && op_reg == HSM_OP_ACQUIRE && flag_reg
         && tries_reg == 4'h0) |-> ##[1:CHK_CMD_MAX] s_strobe_one)
        else $error("failed request not withdrawn");

    chk_init_frees: assert property ((init_reg && !rw_n) |-> port_data_bus_out[0])
        else $error("init wrote zero");

    chk_ready_after_init: assert property (cmd_ready |-> !init_reg)
        else $error("commands taken before tokens freed");

    chk_no_bus_fight: assert property (port_data_bus_oe |-> oe_n)
        else $error("driving data while device outputs enabled");

endmodule : hsm_token_host

`default_nettype wire

// ==== common/hsm_pkg.sv ====
`default_nettype none

package hsm_pkg;

    // token space geometry
    localparam int             TOK_COUNT = 8;
    localparam int             IDX_W     = 3;
    localparam int             DATA_W    = 18;
    localparam logic [2:0]     TOK_LAST  = 3'h7;
    localparam logic [2:0]     TOK_FIRST = 3'h0;

    // clock and bus timing, times in ns, sync latency in cycles
    localparam int             CLK_NS         = 40;
    localparam int             T_WR_PULSE_NS  = 80;
    localparam int             T_RD_ACCESS_NS = 80;
    localparam int             T_GAP_NS       = 40;
    localparam int             SYNC_LAT       = 4;

    // least times round up to whole cycles
    localparam logic [3:0]     WR_CYC  = 4'((T_WR_PULSE_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [3:0]     RD_CYC  = 4'((T_RD_ACCESS_NS + CLK_NS - 1) / CLK_NS + SYNC_LAT);
    localparam logic [3:0]     GAP_CYC = 4'((T_GAP_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [3:0]     CNT_ONE = 4'h1;

    // reset values
    localparam logic [3:0]     POLL_TRIES_RST = 4'h4;
    localparam logic [DATA_W-1:0] BUS_RST     = 18'h00000;

    // user commands
    typedef enum logic [1:0] {
        HSM_OP_TEST    = 2'h0,
        HSM_OP_ACQUIRE = 2'h1,
        HSM_OP_RELEASE = 2'h2
    } hsm_op_t;

endpackage : hsm_pkg

`default_nettype wire

// ==== common/hsm_sync_if.sv ====
`default_nettype none

// carries the raw data pins into the synchroniser and the settled value back
interface hsm_sync_if;
    import hsm_pkg::*;
    logic [DATA_W-1:0] raw;
    logic [DATA_W-1:0] stable;

    modport sync (input raw, output stable);
    modport host (output raw, input stable);
endinterface : hsm_sync_if

`default_nettype wire

// ==== hw/hsm_pin_sync.sv ====
`default_nettype none

module hsm_pin_sync
    import hsm_pkg::*;
(
    input  wire logic   clock,    // system clock
    input  wire logic   rst,      // synchronous reset, high
    hsm_sync_if.sync    sif       // raw pins in, settled value out
);

    // three stage flops and an output flop per bit; the value moves only once stages two and three agree
    genvar b;
    generate
        for (b = 0; b < DATA_W; b++)
        begin : g_bit
            logic s1_reg;
            logic s2_reg;
            logic s3_reg;
            logic st_reg;
            wire logic agree = (s2_reg == s3_reg);  // stage one is never looked at

            always_ff @(posedge clock)
            begin
                if (rst)
                begin
                    s1_reg <= 1'b0;
                    s2_reg <= 1'b0;
                    s3_reg <= 1'b0;
                    st_reg <= 1'b0;
                end
                else
                begin
                    s1_reg <= sif.raw[b];
                    s2_reg <= s1_reg;
                    s3_reg <= s2_reg;
                    if (agree)
                    begin
                        st_reg <= s3_reg;
                    end
                end
            end

            assign sif.stable[b] = st_reg;
        end
    endgenerate

endmodule : hsm_pin_sync

`default_nettype wire

// ==== tb/hsm_dev_model.sv ====
`default_nettype none

// token store seen from both ports; port a faces the host, the bench works port b
module hsm_dev_model
    import hsm_pkg::*;
(
    input  wire logic              a_sel_n, // port a token select
    input  wire logic              a_ce_n,  // port a ram enable
    input  wire logic              a_oe_n,  // port a output enable
    input  wire logic              a_rw_n,  // port a write strobe
    input  wire logic [IDX_W-1:0]  a_idx,   // port a token number
    input  wire logic [DATA_W-1:0] a_out,   // port a host data
    input  wire logic              a_hoe,   // port a host drives
    output logic      [DATA_W-1:0] a_bus,   // port a wire level
    input  wire logic              b_sel_n, // port b token select
    input  wire logic              b_oe_n,  // port b output enable
    input  wire logic              b_rw_n,  // port b write strobe
    input  wire logic [IDX_W-1:0]  b_idx,   // port b token number
    input  wire logic [DATA_W-1:0] b_din,   // port b write data
    output logic      [DATA_W-1:0] b_dout,  // port b read data
    output logic                   bad      // port a broke a pin rule
);
    timeunit 1ns;
    timeprecision 1ns;

    logic [1:0]        own [TOK_COUNT];    // 0 free, 1 port a, 2 port b, apart from ram
    logic              req [2][TOK_COUNT]; // request latches, low requests
    logic              a_q;
    logic              b_q;
    logic [DATA_W-1:0] a_last;
    wire logic         a_rd = !a_sel_n && !a_oe_n && a_ce_n && a_rw_n;
    wire logic         b_rd = !b_sel_n && !b_oe_n && b_rw_n;
    wire logic [DATA_W-1:0] a_val = a_hoe ? a_out : {DATA_W{a_q}};

    // start up held and requested: the host must clear its own side
    initial
    begin
        bad = 1'b0;
        a_q = 1'b1;
        b_q = 1'b1;
        a_last = '0;
        for (int i = 0; i < TOK_COUNT; i++)
        begin
            own[i] = 2'h2;
            req[0][i] = 1'b0;
            req[1][i] = 1'b0;
        end
    end

    function automatic logic flag(input int s, input logic [2:0] i);
        return !(own[i] == 2'(s + 1));
    endfunction : flag

    // a zero on a token the other port holds only parks in its latch
    task automatic wr(input int s, input logic [2:0] i, input logic v);
        req[s][i] = v;
        if (!v && own[i] == 2'h0)
            own[i] = 2'(s + 1); // first writer wins
        else if (v && own[i] == 2'(s + 1))
            own[i] = req[1-s][i] ? 2'h0 : 2'(2 - s);
    endtask : wr

    // writes land at the end of the strobe, bit zero only
    always @(posedge a_rw_n)
        if (!a_sel_n)
            wr(0, a_idx, a_bus[0]);
    always @(posedge b_rw_n)
        if (!b_sel_n)
            wr(1, b_idx, b_din[0]);
    // value frozen at read start, so polling must raise select or output enable between reads
    // short settle so address flops switching in the same step land first
    always @(posedge a_rd)
    begin
        #1;
        a_q = flag(0, a_idx);
    end
    always @(posedge b_rd)
        b_q = flag(1, b_idx);
    // released wire shows the inverse of the last level, never a stale copy
    always @*
        if (a_hoe || a_rd)
            a_last = a_val;
    assign a_bus = (a_hoe || a_rd) ? a_val : ~a_last;
    assign b_dout = b_rd ? {DATA_W{b_q}} : {DATA_W{~b_q}};
    // ram enable low with token select low, or two drivers at once, both count as faults;
    // judged after a settle so flops switching in one step never count
    always @(a_sel_n, a_ce_n, a_hoe, a_rd)
    begin
        #1;
        if ((!a_sel_n && !a_ce_n) || (a_hoe && a_rd))
            bad = 1'b1;
    end
endmodule : hsm_dev_model

`default_nettype wire

// ==== tb/hsm_token_host_tb_top.sv ====
`default_nettype none

module hsm_token_host_tb_top
    import hsm_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    logic              clock, rst, cmd_valid, cmd_ready, rsp_done;
    logic              rsp_granted, rsp_flag, sel_n, ce_n, oe_n, rw_n;
    logic              hoe, bad, b_sel_n, b_oe_n, b_rw_n;
    logic [1:0]        cmd_op;
    logic [IDX_W-1:0]  cmd_index, idx, b_idx;
    logic [DATA_W-1:0] hout, hin, b_dout, b_din;
    int                n_fail = 0;
    int                checks = 0;

    hsm_token_host u_dut (.clock(clock), .rst(rst), .cmd_valid(cmd_valid),
        .cmd_op(cmd_op), .cmd_index(cmd_index), .cmd_ready(cmd_ready),
        .rsp_done(rsp_done), .rsp_granted(rsp_granted), .rsp_flag(rsp_flag),
        .token_select_n(sel_n), .ce_n(ce_n), .oe_n(oe_n), .rw_n(rw_n),
        .token_index(idx), .port_data_bus_in(hin), .port_data_bus_out(hout),
        .port_data_bus_oe(hoe));

    hsm_dev_model u_dev (.a_sel_n(sel_n), .a_ce_n(ce_n), .a_oe_n(oe_n),
        .a_rw_n(rw_n), .a_idx(idx), .a_out(hout), .a_hoe(hoe), .a_bus(hin),
        .b_sel_n(b_sel_n), .b_oe_n(b_oe_n), .b_rw_n(b_rw_n), .b_idx(b_idx),
        .b_din(b_din), .b_dout(b_dout), .bad(bad));

    initial
    begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end

    task automatic close_out();
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : close_out

    task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
        checks++;
        if (got !== exp)
        begin
            n_fail++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic stuck();
        n_fail++;
        $display("wrong value at %0t: wait ran out", $time);
        close_out();
    endtask : stuck

    // one host command, waiting on ready and done under a bound
    task automatic cmd(input hsm_op_t op, input logic [2:0] i);
        for (int n = 0; cmd_ready !== 1'b1; n++)
        begin
            if (n > 300)
                stuck();
            @(negedge clock);
        end
        cmd_valid = 1'b1;
        cmd_op = op;
        cmd_index = i;
        @(negedge clock);
        cmd_valid = 1'b0;
        for (int n = 0; rsp_done !== 1'b1; n++)
        begin
            if (n > 300)
                stuck();
            @(negedge clock);
        end
    endtask : cmd

    task automatic res(input logic g, input logic f);
        chk(DATA_W'(rsp_granted), DATA_W'(g));
        chk(DATA_W'(rsp_flag), DATA_W'(f));
    endtask : res

    // port b write; upper data bits carry the opposite value on purpose
    task automatic bw(input logic [2:0] i, input logic v);
        @(negedge clock);
        b_sel_n = 1'b0;
        b_idx = i;
        b_din = {{(DATA_W-1){~v}}, v};
        @(negedge clock);
        b_rw_n = 1'b0;
        repeat (2) @(negedge clock);
        b_rw_n = 1'b1;
        @(negedge clock);
        b_sel_n = 1'b1;
    endtask : bw

    task automatic br(input logic [2:0] i, input logic e);
        @(negedge clock);
        b_sel_n = 1'b0;
        b_oe_n = 1'b0;
        b_idx = i;
        @(negedge clock);
        chk(b_dout, {DATA_W{e}}); // flag on every bit
        b_sel_n = 1'b1;
        b_oe_n = 1'b1;
    endtask : br

    // both sides clear every token; host init must drop its own requests
    task automatic t_init();
        for (int i = 0; i < TOK_COUNT; i++)
        begin
            bw(3'(i), 1'b1);
            br(3'(i), 1'b1); // port b no longer holds it
        end
    endtask : t_init

    // every token: take, contest, hand over, retake
    task automatic t_pass();
        for (int i = 0; i < TOK_COUNT; i++)
        begin
            cmd(HSM_OP_ACQUIRE, 3'(i));
            res(1'b1, 1'b0);
            br(3'(i), 1'b1);
            bw(3'(i), 1'b0);
            br(3'(i), 1'b1); // loser still reads one
            cmd(HSM_OP_TEST, 3'(i));
            res(1'b1, 1'b0);
            cmd(HSM_OP_RELEASE, 3'(i));
            br(3'(i), 1'b0); // handed over
            cmd(HSM_OP_TEST, 3'(i));
            res(1'b0, 1'b1);
            bw(3'(i), 1'b1);
            cmd(HSM_OP_ACQUIRE, 3'(i));
            res(1'b1, 1'b0); // freed token taken
            cmd(HSM_OP_RELEASE, 3'(i));
        end
    endtask : t_pass

    // failed request must be withdrawn, not left pending
    task automatic t_fail();
        bw(3'h3, 1'b0);
        cmd(HSM_OP_ACQUIRE, 3'h3);
        res(1'b0, 1'b1);
        bw(3'h3, 1'b1);
        cmd(HSM_OP_TEST, 3'h3);
        res(1'b0, 1'b1); // no stale hand-over
    endtask : t_fail

    // release during polling: a later poll must see the token
    task automatic t_poll();
        bw(3'h5, 1'b0);
        fork
            cmd(HSM_OP_ACQUIRE, 3'h5);
            begin
                repeat (25) @(negedge clock);
                bw(3'h5, 1'b1);
            end
        join
        res(1'b1, 1'b0);
        cmd(HSM_OP_RELEASE, 3'h5);
        br(3'h5, 1'b1);
    endtask : t_poll

    // near-simultaneous requests: port b reads the host grant
    task automatic t_tie();
        fork
            cmd(HSM_OP_ACQUIRE, 3'h6);
            bw(3'h6, 1'b0);
        join
        res(1'b1, 1'b0); // host strobe ends half a cycle first, so it wins
        br(3'h6, 1'b1);
        bw(3'h6, 1'b1);
        cmd(HSM_OP_RELEASE, 3'h6);
    endtask : t_tie

    initial
    begin
        rst = 1'b1;
        cmd_valid = 1'b0;
        cmd_op = HSM_OP_TEST;
        cmd_index = '0;
        b_sel_n = 1'b1;
        b_oe_n = 1'b1;
        b_rw_n = 1'b1;
        b_idx = '0;
        b_din = '1;
        repeat (8) @(negedge clock);
        rst = 1'b0;
        cmd(HSM_OP_TEST, 3'h0);
        t_init();
        t_pass();
        t_fail();
        t_poll();
        t_tie();
        chk(DATA_W'(bad), DATA_W'(1'b0)); // ram enable kept high
        close_out();
    end
endmodule : hsm_token_host_tb_top

`default_nettype wire
